// file: common/lcdc_consts.svh
// constants for the lcd column driver host port
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH
// ========================================
// instruction codes
`define LCDC_COL_TAG    2'h1
`define LCDC_LINE_TAG   2'h3
`define LCDC_PAGE_TAG   5'h17
`define LCDC_DISP_TAG   7'h1F
// ========================================
// status bit positions
`define LCDC_ST_BUSY    7
`define LCDC_ST_OFF     5
`define LCDC_ST_RST     4
// ========================================
// sizes and reset values
`define LCDC_COLS       64
`define LCDC_PAGES      8
`define LCDC_LINE_RST   6'h00
`define LCDC_COL_RST    6'h00
`define LCDC_PAGE_RST   3'h0
// internal write is busy for one cycle more than this count
`define LCDC_BUSY_CYC   2'h2
`endif

// file: common/lcdc_pkg.sv
// types for the lcd column driver host port
package lcdc_pkg;
    // host bus group, all pins raw from outside
    typedef struct packed {
        logic       chip_select_a_n;
        logic       chip_select_b_n;
        logic       chip_select_c;
        logic       register_select;
        logic       read_not_write;
        logic       strobe;
        logic [7:0] data;
    } lcdc_bus_type;

    typedef enum logic [1:0] {
        LCDC_OP_INSTR,
        LCDC_OP_STATUS,
        LCDC_OP_WRITE,
        LCDC_OP_READ
    } lcdc_op_type;

    typedef enum {
        LCDC_IDLE,
        LCDC_EXEC
    } lcdc_state_type;
endpackage

// file: core/lcdc_host_port.sv
// host port, display ram and scan addressing of a 64 column lcd driver
// Notes on behaviour
// [RL1] without all three chip selects active, nothing is taken, driven or changed
// [RL2] reset and column direction act regardless of chip selects
// [RL3] write byte latched at strobe fall, then written to ram internally
// [RL4] select/rw: 00 instruction, 01 status, 10 data write, 11 data read
// [RL5] data read returns output register, then reloads it: first read is dummy
// [RL6] status read returns live status with no dummy access
// [RL7] reset low turns display off and clears start line
// [RL8] during reset every access but status read is refused
// [RL9] host polls status until reset and busy bits are clear
// [RL10] busy flag on bit seven high during internal operations
// [RL11] display off forces segments to non-selected level
// [RL12] status bit five reports the on/off flip-flop
// [RL13] on/off changes take effect on the line clock
// [RL14] segments blanked while reset is low
// [RL15] page register loaded only by its instruction, never counts
// [RL16] column counter loaded by instruction, plus one per data access
// [RL17] ram bit one lights the dot, zero leaves it off
// [RL18] column direction high maps column 0 to first segment, low reverses
// [RL19] start line instruction latches data bits zero to five
// [RL20] while frame pulse high, start line presets the line counter
// [RL21] set column: 01 then six-bit column
// [RL22] set page: 10111 then three-bit page
// [RL23] display on/off: 0011111 then on bit, nothing else changes
// [RL24] start line: 11 then six-bit line
// [RL25] busy from write strobe fall until internal execution ends
`include "lcdc_consts.svh"
module lcdc_host_port (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 resetn_i,
    // host bus and device pins
    input  wire lcdc_pkg::lcdc_bus_type bus_i,
    input  wire logic                 reset_in_n_i,
    input  wire logic                 column_dir_i,
    input  wire logic                 line_clock_i,
    input  wire logic                 frame_pulse_i,
    // data bus drive
    output logic [7:0]                data_o,
    output logic                      data_oe_o,
    // scan side
    output logic [5:0]                line_addr_o,
    output logic [63:0]               segment_o,
    output logic                      busy_o
);
    import lcdc_pkg::*;

    // ========================================
    // pin synchronisers: three stages, change counts once 2 and 3 agree
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;
    assign raw_w[13:6] = bus_i.data;
    assign raw_w[5]    = bus_i.chip_select_a_n;
    assign raw_w[4]    = bus_i.chip_select_b_n;
    assign raw_w[3]    = bus_i.chip_select_c;
    assign raw_w[2]    = bus_i.register_select;
    assign raw_w[1]    = bus_i.read_not_write;
    assign raw_w[0]    = bus_i.strobe;
    // the raw reset pin also enters here; only the filtered copy is used
    // a pin that toggles every cycle never passes the filter: levels must stand
    logic [3:0] p_raw_w;
    logic [3:0] p1_q;
    logic [3:0] p2_q;
    logic [3:0] p3_q;
    logic [3:0] pf_q;
    assign p_raw_w[3] = reset_in_n_i;
    assign p_raw_w[2] = column_dir_i;
    assign p_raw_w[1] = line_clock_i;
    assign p_raw_w[0] = frame_pulse_i;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1_q[gi]   <= 1'b0;
                    s2_q[gi]   <= 1'b0;
                    s3_q[gi]   <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw_w[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) filt_q[gi] <= s3_q[gi];
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_psync
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    p1_q[gi] <= 1'b0;
                    p2_q[gi] <= 1'b0;
                    p3_q[gi] <= 1'b0;
                    pf_q[gi] <= 1'b0;
                end else begin
                    p1_q[gi] <= p_raw_w[gi];
                    p2_q[gi] <= p1_q[gi];
                    p3_q[gi] <= p2_q[gi];
                    if (p2_q[gi] == p3_q[gi]) pf_q[gi] <= p3_q[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // decode
    logic [7:0] bus_data_w;
    logic       sel_w;
    logic       strobe_w;
    logic       strobe_prev_q;
    logic       rise_w;
    logic       fall_w;
    logic       rst_pin_w;
    logic       dir_w;
    logic       lclk_w;
    logic       lclk_prev_q;
    logic       frame_w;
    lcdc_op_type op_w;
    assign bus_data_w = filt_q[13:6];
    // only active level on all three selects opens the port
    assign sel_w      = !filt_q[5] && !filt_q[4] && filt_q[3]; // [RL1]
    assign op_w       = lcdc_op_type'({filt_q[2], filt_q[1]}); // [RL4]
    assign strobe_w   = filt_q[0];
    assign rise_w     = strobe_w && !strobe_prev_q;
    assign fall_w     = !strobe_w && strobe_prev_q;
    // reset pin and direction bypass the select gate
    assign rst_pin_w  = !pf_q[3]; // [RL2]
    assign dir_w      = pf_q[2];  // [RL2]
    assign lclk_w     = pf_q[1];
    assign frame_w    = pf_q[0];

    // ========================================
    // state
    lcdc_state_type state_q;
    lcdc_state_type state_d;
    logic [7:0] in_reg_q;
    logic       in_is_data_q;
    logic [7:0] out_reg_q;
    logic [5:0] col_q;
    logic [2:0] page_q;
    logic [5:0] start_q;
    logic [5:0] line_q;
    logic       disp_req_q;
    logic       disp_on_q;
    logic [1:0] busy_cnt_q;
    logic [7:0] ram_q [`LCDC_PAGES][`LCDC_COLS];

    // accepted events: selected, no internal op pending, reset only lets status through
    logic busy_w;
    logic rw_w;
    logic rs_w;
    logic take_wr_w;
    logic take_rd_w;
    assign busy_w    = state_q == LCDC_EXEC;
    assign rw_w      = filt_q[1];
    assign rs_w      = filt_q[2];
    // write accepted at strobe fall; a write during busy is lost, the host must poll
    assign take_wr_w = fall_w && sel_w && !busy_w && !rst_pin_w && !rw_w; // [RL3] [RL8]
    // data read side effect happens at the end of the strobe; ignored while busy
    assign take_rd_w = fall_w && sel_w && !busy_w && !rst_pin_w && op_w == LCDC_OP_READ; // [RL8]

    always_comb begin
        state_d = state_q;
        case (state_q)
            LCDC_IDLE: if (take_wr_w) state_d = LCDC_EXEC; // [RL25]
            LCDC_EXEC: if (busy_cnt_q == 2'h0) state_d = LCDC_IDLE;
            default:   state_d = LCDC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= LCDC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // edge history of the filtered strobe and line clock
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_prev_q <= 1'b0;
            lclk_prev_q   <= 1'b0;
        end else begin
            strobe_prev_q <= strobe_w;
            lclk_prev_q   <= lclk_w;
        end
    end

    // input register holds the byte until the internal operation consumes it
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_reg_q     <= 8'h00;
            in_is_data_q <= 1'b0;
        end else if (take_wr_w) begin
            in_reg_q     <= bus_data_w; // [RL3]
            in_is_data_q <= rs_w;
        end
    end

    // busy counter: fixed length, traded against the host polling rate
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt_q <= 2'h0;
        end else if (take_wr_w) begin
            busy_cnt_q <= `LCDC_BUSY_CYC; // [RL25]
        end else if (busy_cnt_q != 2'h0) begin
            busy_cnt_q <= busy_cnt_q - 2'h1;
        end
    end

    // internal execution on the last busy cycle
    logic exec_w;
    logic exec_data_w;
    logic exec_instr_w;
    assign exec_w       = busy_w && busy_cnt_q == 2'h0;
    assign exec_data_w  = exec_w && in_is_data_q;
    assign exec_instr_w = exec_w && !in_is_data_q;

    // no reset on the ram: contents stay undefined until the host writes them
    always_ff @(posedge sys_clk_i) begin
        if (exec_data_w) ram_q[page_q][col_q] <= in_reg_q; // [RL3]
    end

    // instruction decode of the latched byte; the codes never overlap
    logic is_col_w;
    logic is_page_w;
    logic is_line_w;
    logic is_disp_w;
    assign is_col_w  = in_reg_q[7:6] == `LCDC_COL_TAG;  // [RL21]
    assign is_line_w = in_reg_q[7:6] == `LCDC_LINE_TAG; // [RL24]
    assign is_page_w = in_reg_q[7:3] == `LCDC_PAGE_TAG; // [RL22]
    assign is_disp_w = in_reg_q[7:1] == `LCDC_DISP_TAG; // [RL23]

    // page and start line: loaded by instruction, start line also cleared by the reset pin; the page never counts
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_q  <= `LCDC_PAGE_RST;
            start_q <= `LCDC_LINE_RST;
        end else if (rst_pin_w) begin
            start_q <= `LCDC_LINE_RST; // [RL7]
        end else if (exec_instr_w && is_page_w) begin
            page_q  <= in_reg_q[2:0]; // [RL15]
        end else if (exec_instr_w && is_line_w) begin
            start_q <= in_reg_q[5:0]; // [RL19]
        end
    end

    // display request, applied to the segments on the next line clock
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            disp_req_q <= 1'b0;
        end else if (rst_pin_w) begin
            disp_req_q <= 1'b0; // [RL7]
        end else if (exec_instr_w && is_disp_w) begin
            disp_req_q <= in_reg_q[0]; // [RL23]
        end
    end

    // column counter: loaded by instruction, one step per data access
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            col_q <= `LCDC_COL_RST;
        end else if (exec_instr_w && is_col_w) begin
            col_q <= in_reg_q[5:0]; // [RL16]
        end else if (exec_data_w || take_rd_w) begin
            col_q <= col_q + 6'h01; // [RL16]
        end
    end

    // output register: each data read strobe reloads it, so a read returns the previous fetch
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_reg_q <= 8'h00;
        end else if (take_rd_w) begin
            out_reg_q <= ram_q[page_q][col_q]; // [RL5]
        end
    end

    // ========================================
    // scan side on the line clock
    logic lclk_rise_w;
    assign lclk_rise_w = lclk_w && !lclk_prev_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            disp_on_q <= 1'b0;
            line_q    <= `LCDC_LINE_RST;
        end else begin
            if (rst_pin_w) disp_on_q <= 1'b0;               // [RL7]
            else if (lclk_rise_w) disp_on_q <= disp_req_q;  // [RL13]
            if (frame_w) line_q <= start_q;                 // [RL20]
            else if (lclk_rise_w) line_q <= line_q + 6'h01;
        end
    end

    // ========================================
    // segments: bit of the current line in every column
    logic [63:0] seg_w;
    generate
        for (gi = 0; gi < `LCDC_COLS; gi++) begin : g_seg
            // dir high: column gi drives segment gi, low: reversed
            logic [5:0] c_w;
            assign c_w = dir_w ? 6'(gi) : 6'(`LCDC_COLS - 1 - gi); // [RL18]
            // ram one lights the dot, off or reset forces the non-selected level
            assign seg_w[gi] = disp_on_q && !rst_pin_w
                             && ram_q[line_q[5:3]][c_w][line_q[2:0]]; // [RL11] [RL14] [RL17]
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) segment_o <= 64'h0;
        else           segment_o <= seg_w;
    end

    // ========================================
    // bus drive: status is live, data reads give the latched byte
    logic [7:0] status_w;
    always_comb begin
        status_w = 8'h00;
        status_w[`LCDC_ST_BUSY] = busy_w;     // [RL10]
        status_w[`LCDC_ST_OFF]  = !disp_on_q; // [RL12]
        status_w[`LCDC_ST_RST]  = rst_pin_w;
    end
    assign data_oe_o = sel_w && strobe_w && filt_q[1]; // [RL1]
    // bus byte from a flip-flop; it lags the live status by one cycle
    logic [7:0] data_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_q <= 8'h00;
        end else begin
            data_q <= op_w == LCDC_OP_STATUS ? status_w : out_reg_q; // [RL6] [RL5]
        end
    end
    assign data_o    = data_q;
    assign busy_o    = busy_w;
    assign line_addr_o = line_q;
endmodule

// file: test/lcdc_checker.sv
// concurrent checks on the lcd column driver host port
module lcdc_checker (
    // clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   resetn_i,
    // watched pins
    input wire lcdc_pkg::lcdc_bus_type bus_i,
    input wire logic                   reset_in_n_i,
    input wire logic                   frame_pulse_i,
    input wire logic [7:0]             data_o,
    input wire logic                   data_oe_o,
    input wire logic [5:0]             line_addr_o,
    input wire logic [63:0]            segment_o,
    input wire logic                   busy_o
);
    import lcdc_pkg::*;
    // ========================================
    // helpers
    // six steady cycles cover the input synchronisers
    wire sel_w = !bus_i.chip_select_a_n && !bus_i.chip_select_b_n && bus_i.chip_select_c;
    wire rd_w  = sel_w && bus_i.read_not_write && bus_i.strobe && reset_in_n_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // ========================================
    // properties
    property p_oe_desel; !bus_i.chip_select_c [*6] |-> !data_oe_o; endproperty
    a_oe_desel: assert property (p_oe_desel) else $error("bus driven while deselected");
    property p_oe_write; !bus_i.read_not_write [*6] |-> !data_oe_o; endproperty
    a_oe_write: assert property (p_oe_write) else $error("bus driven during write");
    property p_oe_read; rd_w [*6] |-> data_oe_o; endproperty
    a_oe_read: assert property (p_oe_read) else $error("selected read not driven");
    property p_status; (data_oe_o && !bus_i.register_select) [*6] |->
        data_o[7] == $past(busy_o) && data_o[6] == 1'b0 && data_o[3:0] == 4'h0; endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_seg_blank; !reset_in_n_i [*6] |-> segment_o == 64'h0; endproperty
    a_seg_blank: assert property (p_seg_blank) else $error("segments lit in reset");
    property p_busy_len; $rose(busy_o) |-> ##[1:4] !busy_o; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_rst_idle; !reset_in_n_i [*8] |-> !busy_o; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("work accepted in reset");
    property p_preset; frame_pulse_i [*8] |-> $stable(line_addr_o); endproperty
    a_preset: assert property (p_preset) else $error("line moved during frame");
    c_write: cover property ($rose(busy_o));
    c_read: cover property (data_oe_o && bus_i.register_select);
    c_frame: cover property (frame_pulse_i && line_addr_o != 6'h00);
endmodule

bind lcdc_host_port lcdc_checker chk (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .bus_i         (bus_i),
    .reset_in_n_i  (reset_in_n_i),
    .frame_pulse_i (frame_pulse_i),
    .data_o        (data_o),
    .data_oe_o     (data_oe_o),
    .line_addr_o   (line_addr_o),
    .segment_o     (segment_o),
    .busy_o        (busy_o)
);

// file: test/lcdc_host_model.sv
// processor model driving the host strobe bus of the lcd driver
module lcdc_host_model (
    // clock
    input  wire logic              sys_clk_i,
    // bus to and from the device
    output lcdc_pkg::lcdc_bus_type bus_o,
    input  wire logic [7:0]        data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import lcdc_pkg::*;
    // ========================================
    // one access: strobe high 8 cycles, low 12, past sync and busy time
    initial bus_o = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
    task automatic access(input logic rs, rd, sel, input logic [7:0] wd,
                          output logic [7:0] q);
        @(negedge sys_clk_i);
        bus_o.chip_select_c = sel;
        bus_o.register_select = rs;
        bus_o.read_not_write = rd;
        // a released data bus reads back inverted, never a stale copy
        bus_o.data = rd ? ~bus_o.data : wd;
        @(negedge sys_clk_i);
        bus_o.strobe = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        // sampled off the edge, once the output flip-flop has settled
        q = data_i;
        bus_o.strobe = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        bus_o.chip_select_c = 1'b0;
    endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the lcd column driver host port
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lcdc_pkg::*;
    // ========================================
    // signals
    logic         sys_clk_i     = 1'b0;
    logic         resetn_i      = 1'b0;
    logic         reset_in_n_i  = 1'b1;
    logic         column_dir_i  = 1'b1;
    logic         line_clock_i  = 1'b0;
    logic         frame_pulse_i = 1'b0;
    lcdc_bus_type bus;
    logic [7:0]   data_o;
    logic         data_oe_o;
    logic [5:0]   line_addr_o;
    logic [63:0]  segment_o;
    logic         busy_o;
    logic [7:0]   q;
    int           miscompares = 0;
    int           tests_run   = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    // line clock flips on falling edges, rising every 40 cycles
    always #2000 line_clock_i = ~line_clock_i;
    lcdc_host_model host (.sys_clk_i(sys_clk_i), .bus_o(bus), .data_i(data_o));
    lcdc_host_port uut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus),
        .reset_in_n_i(reset_in_n_i), .column_dir_i(column_dir_i),
        .line_clock_i(line_clock_i), .frame_pulse_i(frame_pulse_i),
        .data_o(data_o), .data_oe_o(data_oe_o), .line_addr_o(line_addr_o),
        .segment_o(segment_o), .busy_o(busy_o));
    // ========================================
    // shared tasks
    task automatic check(input string name, input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic op(input logic rs, rd, input logic [7:0] wd);
        host.access(rs, rd, 1'b1, wd, q);
    endtask
    task automatic expect_rd(input logic rs, input string name, input logic [7:0] exp);
        op(rs, 1'b1, 8'h00);
        check(name, q, exp);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 20; i++) begin
            op(1'b0, 1'b1, 8'h00);
            if ((q & 8'h90) === 8'h00) return;
        end
        check("ready poll", 1'b0, 1'b1);
        conclude();
    endtask
    task automatic frame_line(input logic [5:0] exp);
        @(negedge sys_clk_i) frame_pulse_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        check("line preset", line_addr_o, exp);
        frame_pulse_i = 1'b0;
    endtask
    // ========================================
    // scenarios
    task automatic t_pin_reset();
        @(negedge sys_clk_i) reset_in_n_i = 1'b0;
        op(1'b0, 1'b0, 8'h3F);
        expect_rd(1'b0, "status in reset", 8'h30);
        check("segments in reset", segment_o, 64'h0);
        @(negedge sys_clk_i) reset_in_n_i = 1'b1;
        wait_ready();
        expect_rd(1'b0, "status after reset", 8'h20);
        check("segments when off", segment_o, 64'h0);
    endtask
    task automatic t_display();
        op(1'b0, 1'b0, 8'h3F);
        repeat (50) @(negedge sys_clk_i);
        expect_rd(1'b0, "status display on", 8'h00);
    endtask
    task automatic t_ram();
        op(1'b0, 1'b0, 8'hBB);
        op(1'b0, 1'b0, 8'h45);
        op(1'b1, 1'b0, 8'hA5);
        op(1'b1, 1'b0, 8'h3C);
        op(1'b0, 1'b0, 8'hBC);
        op(1'b0, 1'b0, 8'h45);
        op(1'b1, 1'b0, 8'h11);
        op(1'b0, 1'b0, 8'hBB);
        op(1'b0, 1'b0, 8'h45);
        op(1'b1, 1'b1, 8'h00); // first data read is discarded
        expect_rd(1'b1, "ram first byte", 8'hA5);
        expect_rd(1'b1, "ram next column", 8'h3C);
    endtask
    task automatic t_segment();
        op(1'b0, 1'b0, 8'hD8);
        @(negedge sys_clk_i) frame_pulse_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        check("dot on", segment_o[5], 1'b1);
        check("dot off", segment_o[6], 1'b0);
        column_dir_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        check("mirrored dot on", segment_o[58], 1'b1);
        check("mirrored dot off", segment_o[57], 1'b0);
        column_dir_i = 1'b1;
        frame_pulse_i = 1'b0;
    endtask
    task automatic t_desel();
        host.access(1'b0, 1'b0, 1'b0, 8'h3E, q);
        repeat (50) @(negedge sys_clk_i);
        expect_rd(1'b0, "status after deselected write", 8'h00);
    endtask
    task automatic t_start();
        op(1'b0, 1'b0, 8'hEA);
        frame_line(6'h2A);
        @(negedge sys_clk_i) reset_in_n_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        reset_in_n_i = 1'b1;
        wait_ready();
        frame_line(6'h00);
    endtask
    initial begin
        repeat (16) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        t_pin_reset();
        t_display();
        t_ram();
        t_segment();
        t_desel();
        t_start();
        conclude();
    end
endmodule
